/* logic/ltssm_map.vh */
// Link training state codes, ordered-set symbols and timing counts
`ifndef LTSSM_MAP_VH
`define LTSSM_MAP_VH
`define ST_DETECT_QUIET    6'h00
`define ST_DETECT_ACTIVE   6'h02
`define ST_POLL_ACTIVE     6'h04
`define ST_POLL_CONFIG     6'h05
`define ST_CFG_LW_START0   6'h0B
`define ST_CFG_LW_START1   6'h0C
`define ST_CFG_LW_ACCEPT0  6'h0D
`define ST_CFG_LW_ACCEPT1  6'h0E
`define ST_CFG_LN_WAIT     6'h0F
`define ST_CFG_LN_ACCEPT   6'h10
`define ST_CFG_COMPLETE_X1 6'h11
`define ST_CFG_IDLE        6'h15
`define SYM_COM            8'hBC
`define SYM_PAD            8'hF7
`define SYM_TS1_ID         8'h4A
`define SYM_TS2_ID         8'h45
`define NFTS_COUNT         8'hFF
`define RX_STATUS_PRESENT  3'h3
`define TS1_MIN_COUNT      11'h400
`define TS2_RX_NEEDED      4'h8
`define TS2_TX_NEEDED      5'h10
`define OS_SYMBOLS         4'hF
`endif

/* logic/os_symbol_rom.v */
// Ordered-set symbol generator with registered output
`timescale 1ns/1ps
`include "ltssm_map.vh"
module os_symbol_rom (
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire [3:0] sym_index,
    input  wire       is_ts2,
    input  wire [7:0] link_field,
    input  wire [7:0] lane_field,
    output reg  [7:0] sym_data,
    output reg        sym_is_k
);
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sym_data <= 8'h00;
            sym_is_k <= 1'b0;
        end else begin
            sym_is_k <= 1'b0;
            case (sym_index)
                4'h0: begin
                    sym_data <= `SYM_COM;
                    sym_is_k <= 1'b1;
                end
                4'h1: begin
                    sym_data <= link_field;
                    sym_is_k <= (link_field == `SYM_PAD);
                end
                4'h2: begin
                    sym_data <= lane_field;
                    sym_is_k <= (lane_field == `SYM_PAD);
                end
                4'h3: sym_data <= `NFTS_COUNT;
                4'h4: sym_data <= 8'h06;
                4'h5: sym_data <= 8'h00;
                default: sym_data <= is_ts2 ? `SYM_TS2_ID : `SYM_TS1_ID;
            endcase
        end
    end
endmodule

/* logic/link_trainer.v */
// Link training sequencer: detect, polling and configuration
// Overview of operation
// - In detect, raise the receiver-detect request toward every lane.
// - After detection, drop detect request, then release electrical idle.
// - On entering polling, send TS1 at once without waiting for partner.
// - Report polling sub-states 4 and 5 on the state code.
// - Polling TS1 carries PAD F7 in link and lane fields.
// - TS1 identifier is 4A, TS2 is 45; receiver distinguishes by them.
// - Send at least 1024 TS1 sets for bit and symbol lock.
// - Leave polling after eight TS2 received and 16 TS2 sent.
// - Keep sending current sets until moving state on own decision.
// - Accept downstream link number by echoing it in TS1 sets.
// - After link agreed, echo proposed lane number instead of PAD.
// - Report configuration sub-states B, D, 10 and 11 on the state code.
// - Advertise N_FTS of FF in training sets.
`timescale 1ns/1ps
`include "ltssm_map.vh"
module link_trainer #(
    parameter LANES = 4
) (
    input  wire             clk_sys,
    input  wire             rst_b,
    input  wire [LANES-1:0] rx_phy_handshake_flag,
    input  wire [3*LANES-1:0] lane_rx_status_code,
    input  wire [7:0]       rx_data,
    input  wire             rx_is_k,
    output reg              tx_detect_rx,
    output reg  [LANES-1:0] tx_idle_request,
    output reg  [7:0]       tx_data,
    output reg              tx_is_k,
    output reg  [5:0]       training_state_code,
    output reg  [7:0]       agreed_link_number
);
    localparam S_DET_QUIET = 7'b0000001;
    localparam S_DET_ACT   = 7'b0000010;
    localparam S_DET_DONE  = 7'b0000100;
    localparam S_POLL_ACT  = 7'b0001000;
    localparam S_POLL_CFG  = 7'b0010000;
    localparam S_CFG_LINK  = 7'b0100000;
    localparam S_CFG_LANE  = 7'b1000000;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg [LANES-1:0]   flag_meta;
    reg [LANES-1:0]   flag_sync;
    reg [3*LANES-1:0] status_meta;
    reg [3*LANES-1:0] status_sync;
    reg [7:0]         rxd_meta;
    reg [7:0]         rxd_sync;
    reg               rxk_meta;
    reg               rxk_sync;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flag_meta   <= {LANES{1'b0}};
            flag_sync   <= {LANES{1'b0}};
            status_meta <= {3*LANES{1'b0}};
            status_sync <= {3*LANES{1'b0}};
            rxd_meta    <= 8'h00;
            rxd_sync    <= 8'h00;
            rxk_meta    <= 1'b0;
            rxk_sync    <= 1'b0;
        end else begin
            flag_meta   <= rx_phy_handshake_flag;
            flag_sync   <= flag_meta;
            status_meta <= lane_rx_status_code;
            status_sync <= status_meta;
            rxd_meta    <= rx_data;
            rxd_sync    <= rxd_meta;
            rxk_meta    <= rx_is_k;
            rxk_sync    <= rxk_meta;
        end
    end

    // ------------------------------------------------------------
    // Per-lane receiver presence
    // ------------------------------------------------------------
    wire [LANES-1:0] lane_found;
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_det
            assign lane_found[g] = flag_sync[g] &&
                (status_sync[3*g+2:3*g] == `RX_STATUS_PRESENT);
        end
    endgenerate

    // ------------------------------------------------------------
    // Received ordered-set parser
    // ------------------------------------------------------------
    reg [3:0] rx_pos;
    reg [7:0] rx_link;
    reg [7:0] rx_lane;
    reg       rx_set_done;
    reg       rx_set_ts2;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_pos      <= 4'h0;
            rx_link     <= `SYM_PAD;
            rx_lane     <= `SYM_PAD;
            rx_set_done <= 1'b0;
            rx_set_ts2  <= 1'b0;
        end else begin
            rx_set_done <= 1'b0;
            if (rxk_sync && rxd_sync == `SYM_COM) begin
                rx_pos <= 4'h1;
            end else if (rx_pos != 4'h0) begin
                if (rx_pos == 4'h1) rx_link <= rxd_sync;
                if (rx_pos == 4'h2) rx_lane <= rxd_sync;
                if (rx_pos == `OS_SYMBOLS) begin
                    rx_pos      <= 4'h0;
                    rx_set_done <= (rxd_sync == `SYM_TS1_ID) ||
                                   (rxd_sync == `SYM_TS2_ID);
                    rx_set_ts2  <= (rxd_sync == `SYM_TS2_ID);
                end else begin
                    rx_pos <= rx_pos + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit symbol sequencer
    // ------------------------------------------------------------
    reg  [3:0]  tx_pos;
    reg         tx_ts2;
    reg  [7:0]  tx_link_field;
    reg  [7:0]  tx_lane_field;
    wire [7:0]  rom_data;
    wire        rom_k;
    reg         tx_on;
    wire        tx_set_end = tx_on && (tx_pos == `OS_SYMBOLS);

    os_symbol_rom u_rom (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .sym_index  (tx_pos),
        .is_ts2     (tx_ts2),
        .link_field (tx_link_field),
        .lane_field (tx_lane_field),
        .sym_data   (rom_data),
        .sym_is_k   (rom_k)
    );

    // ------------------------------------------------------------
    // Main state machine
    // ------------------------------------------------------------
    reg [6:0]  state;
    reg [10:0] ts1_sent;
    reg [3:0]  ts2_rx_run;
    reg [4:0]  ts2_tx_cnt;
    reg        ts2_seen;
    reg        tx_on_d;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state               <= S_DET_QUIET;
            tx_detect_rx        <= 1'b0;
            tx_idle_request     <= {LANES{1'b1}};
            tx_on               <= 1'b0;
            tx_on_d             <= 1'b0;
            tx_pos              <= 4'h0;
            tx_ts2              <= 1'b0;
            tx_link_field       <= `SYM_PAD;
            tx_lane_field       <= `SYM_PAD;
            ts1_sent            <= 11'h000;
            ts2_rx_run          <= 4'h0;
            ts2_tx_cnt          <= 5'h00;
            ts2_seen            <= 1'b0;
            tx_data             <= 8'h00;
            tx_is_k             <= 1'b0;
            training_state_code <= `ST_DETECT_QUIET;
            agreed_link_number  <= `SYM_PAD;
        end else begin
            tx_on_d <= tx_on;
            tx_data <= tx_on_d ? rom_data : 8'h00;
            tx_is_k <= tx_on_d ? rom_k : 1'b0;
            if (tx_on)
                tx_pos <= (tx_pos == `OS_SYMBOLS) ? 4'h0 : tx_pos + 4'h1;
            case (state)
                S_DET_QUIET: begin
                    state               <= S_DET_ACT;
                    training_state_code <= `ST_DETECT_QUIET;
                end
                S_DET_ACT: begin
                    tx_detect_rx        <= 1'b1;
                    training_state_code <= `ST_DETECT_ACTIVE;
                    if (|lane_found) begin
                        tx_detect_rx <= 1'b0;
                        state        <= S_DET_DONE;
                    end
                end
                S_DET_DONE: begin
                    tx_idle_request <= {LANES{1'b0}};
                    tx_on           <= 1'b1;
                    tx_pos          <= 4'h0;
                    tx_link_field   <= `SYM_PAD;
                    tx_lane_field   <= `SYM_PAD;
                    state           <= S_POLL_ACT;
                    training_state_code <= `ST_POLL_ACTIVE;
                end
                S_POLL_ACT: begin
                    if (tx_set_end && ts1_sent != `TS1_MIN_COUNT)
                        ts1_sent <= ts1_sent + 11'h001;
                    if (ts1_sent == `TS1_MIN_COUNT && tx_set_end) begin
                        tx_ts2              <= 1'b1;
                        state               <= S_POLL_CFG;
                        training_state_code <= `ST_POLL_CONFIG;
                    end
                end
                S_POLL_CFG: begin
                    if (rx_set_done) begin
                        ts2_rx_run <= !rx_set_ts2 ? 4'h0 :
                                      (ts2_rx_run == `TS2_RX_NEEDED) ? ts2_rx_run :
                                      ts2_rx_run + 4'h1;
                        if (rx_set_ts2) ts2_seen <= 1'b1;
                    end
                    if (tx_set_end && ts2_seen && ts2_tx_cnt != `TS2_TX_NEEDED)
                        ts2_tx_cnt <= ts2_tx_cnt + 5'h01;
                    if (tx_set_end && ts2_rx_run == `TS2_RX_NEEDED &&
                        ts2_tx_cnt == `TS2_TX_NEEDED) begin
                        tx_ts2              <= 1'b0;
                        state               <= S_CFG_LINK;
                        training_state_code <= `ST_CFG_LW_START0;
                    end
                end
                S_CFG_LINK: begin
                    if (rx_set_done && !rx_set_ts2 && rx_link != `SYM_PAD) begin
                        tx_link_field       <= rx_link;
                        agreed_link_number  <= rx_link;
                        training_state_code <= `ST_CFG_LW_ACCEPT0;
                        state               <= S_CFG_LANE;
                    end
                end
                S_CFG_LANE: begin
                    if (rx_set_done && rx_lane != `SYM_PAD) begin
                        tx_lane_field       <= rx_lane;
                        training_state_code <= `ST_CFG_LN_ACCEPT;
                    end
                    if (rx_set_done && rx_set_ts2)
                        training_state_code <= `ST_CFG_COMPLETE_X1;
                end
                default: state <= S_DET_QUIET;
            endcase
        end
    end
endmodule

/* bench/link_trainer_sva.sv */
// Assertion checker for the link training sequencer
`timescale 1ns/1ps
`include "ltssm_map.vh"
module link_trainer_sva #(
    parameter LANES = 4
) (
    input wire             clk_sys,
    input wire             rst_b,
    input wire             tx_detect_rx,
    input wire [LANES-1:0] tx_idle_request,
    input wire [7:0]       tx_data,
    input wire             tx_is_k,
    input wire [5:0]       training_state_code
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    wire        com = tx_is_k && tx_data == `SYM_COM;
    wire        p_act = training_state_code == `ST_POLL_ACTIVE;
    wire        p_cfg = training_state_code == `ST_POLL_CONFIG;
    reg  [11:0] ts1_sent;
    reg  [5:0]  ts2_sent;
    // Sets started per polling sub-state, saturating
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ts1_sent <= 12'h000;
            ts2_sent <= 6'h00;
        end else begin
            if (com && p_act && !(&ts1_sent))
                ts1_sent <= ts1_sent + 12'h001;
            if (com && p_cfg && !(&ts2_sent))
                ts2_sent <= ts2_sent + 6'h01;
        end
    end
    AST_IDLE_HELD: assert property (tx_detect_rx |-> &tx_idle_request)
        else $error("idle released during detection");
    AST_IDLE_AFTER: assert property ($fell(tx_detect_rx) |=> !(&tx_idle_request))
        else $error("idle not released after detection");
    AST_TS1_PROMPT: assert property ($fell(tx_idle_request[0]) |-> ##[1:5] com)
        else $error("no ordered set after idle exit");
    AST_POLL_PAD: assert property ((p_act || p_cfg) && com |=>
        tx_is_k && tx_data == `SYM_PAD ##1 tx_data == `SYM_PAD ##1 tx_data == `NFTS_COUNT)
        else $error("polling set fields wrong");
    AST_TS1_ID: assert property (p_act && com |-> ##15 tx_data == `SYM_TS1_ID)
        else $error("first training set id wrong");
    AST_TS2_ID: assert property (p_cfg && com |-> ##6 tx_data == `SYM_TS2_ID)
        else $error("second training set id wrong");
    AST_TS1_COUNT: assert property (p_cfg && com |-> ts1_sent >= 12'h400)
        else $error("too few first training sets");
    AST_TS2_COUNT: assert property (p_cfg ##1
        training_state_code == `ST_CFG_LW_START0 |-> ts2_sent >= 6'h10)
        else $error("left polling too early");
    AST_SET_WHOLE: assert property (com |-> ##15
        (tx_data == `SYM_TS1_ID || tx_data == `SYM_TS2_ID))
        else $error("ordered set cut short");
endmodule
bind link_trainer link_trainer_sva #(.LANES(LANES)) sva_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .tx_detect_rx(tx_detect_rx),
    .tx_idle_request(tx_idle_request), .tx_data(tx_data), .tx_is_k(tx_is_k),
    .training_state_code(training_state_code)
);

/* bench/remote_partner.sv */
// Remote link partner model sending ordered sets on the receive stream
`timescale 1ns/1ps
`include "ltssm_map.vh"
module remote_partner (
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire [1:0] os_kind,
    input  wire [7:0] link_num,
    input  wire [7:0] lane_num,
    output reg  [7:0] rx_data,
    output reg        rx_is_k
);
    reg [3:0] idx;
    reg [1:0] cur;
    reg [7:0] link_q;
    reg [7:0] lane_q;
    // Content changes only at set boundaries
    always @(negedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idx    <= 4'h0;
            cur    <= 2'h0;
            link_q <= `SYM_PAD;
            lane_q <= `SYM_PAD;
        end else begin
            idx <= idx + 4'h1;
            if (idx == 4'hF) begin
                cur <= os_kind;
                link_q <= link_num;
                lane_q <= lane_num;
            end
        end
    end
    always @* begin
        case (idx)
            4'h0: rx_data = `SYM_COM;
            4'h1: rx_data = link_q;
            4'h2: rx_data = lane_q;
            4'h3: rx_data = `NFTS_COUNT;
            4'h4: rx_data = 8'h06;
            4'h5: rx_data = 8'h00;
            default: rx_data = (cur == 2'd2) ? `SYM_TS2_ID : `SYM_TS1_ID;
        endcase
        rx_is_k = idx == 4'h0 || (idx < 4'h3 && rx_data == `SYM_PAD);
        if (cur == 2'd0) begin
            rx_data = 8'h00;
            rx_is_k = 1'b0;
        end
    end
endmodule

/* bench/link_trainer_tb_top.sv */
// Self-checking testbench for the link training sequencer
`timescale 1ns/1ps
`include "ltssm_map.vh"
module link_trainer_tb_top;
    reg         clk_sys;
    reg         rst_b;
    reg  [3:0]  flag;
    reg  [11:0] status;
    reg  [1:0]  os_kind;
    reg  [7:0]  link_num;
    reg  [7:0]  lane_num;
    wire [7:0]  rx_data;
    wire        rx_is_k;
    wire        tx_detect_rx;
    wire [3:0]  tx_idle_request;
    wire [7:0]  tx_data;
    wire        tx_is_k;
    wire [5:0]  code;
    wire [7:0]  agreed;
    reg  [7:0]  os [0:15];
    integer     fail_count;
    integer     checks;
    integer     n;
    integer     k;
    link_trainer #(.LANES(4)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
        .rx_phy_handshake_flag(flag), .lane_rx_status_code(status), .rx_data(rx_data),
        .rx_is_k(rx_is_k), .tx_detect_rx(tx_detect_rx), .tx_idle_request(tx_idle_request),
        .tx_data(tx_data), .tx_is_k(tx_is_k), .training_state_code(code),
        .agreed_link_number(agreed));
    remote_partner partner_u (.clk_sys(clk_sys), .rst_b(rst_b), .os_kind(os_kind),
        .link_num(link_num), .lane_num(lane_num), .rx_data(rx_data), .rx_is_k(rx_is_k));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task check(input [31:0] seen, input [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wait_code(input [5:0] c);
        for (n = 0; code !== c && n < 40000; n = n + 1)
            @(negedge clk_sys);
    endtask
    task grab;
        for (n = 0; !(tx_is_k === 1'b1 && tx_data === `SYM_COM) && n < 64; n = n + 1)
            @(negedge clk_sys);
        for (k = 0; k < 16; k = k + 1) begin
            os[k] = tx_data;
            @(negedge clk_sys);
        end
    endtask
    task t_reset;
        check(tx_idle_request, 4'hF);
        check(agreed, `SYM_PAD);
        rst_b = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        check(tx_detect_rx, 1'b1);
        check(code, `ST_DETECT_ACTIVE);
    endtask
    task t_detect;
        @(negedge clk_sys);
        flag = 4'hF;
        @(negedge clk_sys);
        flag = 4'h0;
        repeat (8) @(negedge clk_sys);
        check(tx_detect_rx, 1'b1);
        status = 12'h6DB;
        flag = 4'hF;
        @(negedge clk_sys);
        flag = 4'h0;
        for (n = 0; tx_detect_rx !== 1'b0 && n < 12; n = n + 1)
            @(negedge clk_sys);
        status = 12'h000;
        check(tx_idle_request, 4'hF);
        @(negedge clk_sys);
        check(tx_idle_request, 4'h0);
    endtask
    task t_poll;
        grab;
        check(code, `ST_POLL_ACTIVE);
        check({os[0], os[1], os[2], os[3]}, 32'hBCF7_F7FF);
        check(os[15], `SYM_TS1_ID);
        os_kind = 2'd1;
        for (n = 1; code === `ST_POLL_ACTIVE && n < 2000; ) begin
            if (tx_is_k === 1'b1 && tx_data === `SYM_COM)
                n = n + 1;
            @(negedge clk_sys);
        end
        check(n >= 1024, 1'b1);
        check(code, `ST_POLL_CONFIG);
    endtask
    task t_poll_cfg;
        grab;
        check(os[15], `SYM_TS2_ID);
        // Partner keeps its first sets going long enough for lock
        repeat (64) @(negedge clk_sys);
        os_kind = 2'h2;
        for (n = 1; code === `ST_POLL_CONFIG && n < 2000; ) begin
            if (tx_is_k === 1'b1 && tx_data === `SYM_COM)
                n = n + 1;
            @(negedge clk_sys);
        end
        check(n >= 16, 1'b1);
        check(code, `ST_CFG_LW_START0);
    endtask
    task t_cfg;
        os_kind = 2'd1;
        link_num = 8'h05;
        wait_code(`ST_CFG_LW_ACCEPT0);
        check(code, `ST_CFG_LW_ACCEPT0);
        check(agreed, 8'h05);
        grab;
        grab;
        check({os[1], os[2]}, 16'h05F7);
        lane_num = 8'h00;
        wait_code(`ST_CFG_LN_ACCEPT);
        check(code, `ST_CFG_LN_ACCEPT);
        grab;
        grab;
        check({os[1], os[2], os[3]}, 24'h05_00FF);
        os_kind = 2'd2;
        wait_code(`ST_CFG_COMPLETE_X1);
        check(code, `ST_CFG_COMPLETE_X1);
    endtask
    initial begin
        rst_b = 1'b0;
        flag = 4'h0;
        status = 12'h000;
        os_kind = 2'd0;
        link_num = `SYM_PAD;
        lane_num = `SYM_PAD;
        fail_count = 0;
        checks = 0;
        repeat (6) @(negedge clk_sys);
        t_reset;
        t_detect;
        t_poll;
        t_poll_cfg;
        t_cfg;
        summarize;
    end
    initial begin
        #600000;
        fail_count = fail_count + 1;
        summarize;
    end
endmodule
